//--- common/pac_cfg.svh
// Offsets, field positions, reset values and timing for the port address counter
`ifndef PAC_CFG_SVH
`define PAC_CFG_SVH

// ============================================================
// Geometry
`define PAC_ADDR_W 16
`define PAC_HADDR_W 8

// ============================================================
// Register byte offsets on the bus
`define PAC_OFS_COUNT 8'h00
`define PAC_OFS_MASK 8'h04
`define PAC_OFS_CTRL 8'h08
`define PAC_OFS_STAT 8'h0C

// ============================================================
// Field positions
`define PAC_CTRL_RB_EN 0
`define PAC_STAT_OP_LSB 0
`define PAC_STAT_SEL 4
`define PAC_STAT_DRV 5

// ============================================================
// Reset values
`define PAC_CNT_RST_BIT 1'b0
`define PAC_MASK_RST_BIT 1'b1
`define PAC_RB_EN_RST 1'b1

// ============================================================
// Bus coding
`define PAC_HSIZE_WORD 3'h2
`define PAC_READ_LAT 1

`endif

//--- common/pac_pkg.sv
// Types shared by the port address counter design
package pac_pkg;

    // ============================================================
    // Counter control pins of one port, all active low
    typedef struct packed {
        logic counter_reset_n;
        logic mask_load_n;
        logic counter_load_n;
        logic counter_increment_n;
        logic counter_readback_n;
        logic mask_readback_n;
    } pac_ctrl_t;

    // ============================================================
    // Operation taken by the counter at an edge
    typedef enum logic [2:0] {
        PAC_OP_MASTER_RESET_N = 3'b000,
        PAC_OP_CRST = 3'b001,
        PAC_OP_MASK_LD = 3'b010,
        PAC_OP_ADDR_LD = 3'b011,
        PAC_OP_INC = 3'b100,
        PAC_OP_HOLD = 3'b101
    } pac_op_t;

endpackage

//--- hdl/pac_port_counter.sv
// Burst address counter and counter mask of one memory port
// Operation
// - Counter reset low gives address zero
// - Master reset clears counter, sets mask
// - Mask load copies address, counter holds
// - Address load puts external address in
// - Increment advances counter despite enables
// - Advance follows mask; default steps one
// - Reset and load ignore chip enables
// - Counter and mask ignore chip enables
// - Counter readback drives address lines
// - Mask readback when counter readback high
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pac_cfg.svh"

module pac_port_counter
    import pac_pkg::*;
#(
    parameter int ADDR_W = `PAC_ADDR_W
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic master_reset_n,
    input wire pac_ctrl_t ctrl,
    input wire logic chip_enable_low_active,
    input wire logic chip_enable_high_active,
    input wire logic lower_byte_enable_n,
    input wire logic upper_byte_enable_n,
    input wire logic [ADDR_W-1:0] external_address,
    output logic [ADDR_W-1:0] address_drive,
    output logic address_drive_en_n,
    output logic [ADDR_W-1:0] internal_address,
    output logic access_selected,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic hwrite,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    // ============================================================
    // State
    typedef struct packed {
        logic [ADDR_W-1:0] counter;
        logic [ADDR_W-1:0] mask;
        logic [ADDR_W-1:0] drive;
        logic drive_en_n;
        logic selected;
        pac_op_t last_op;
        logic rb_en;
        logic ap_write;
        logic [`PAC_HADDR_W-1:0] ap_addr;
        logic [31:0] rdata;
        logic ready;
    } pac_state_t;

    // Reset image; constants only, safe for the asynchronous path
    localparam pac_state_t ST_INIT = '{
        counter: {ADDR_W{`PAC_CNT_RST_BIT}},
        mask: {ADDR_W{`PAC_MASK_RST_BIT}},
        drive: '0,
        drive_en_n: 1'b1,
        selected: 1'b0,
        last_op: PAC_OP_MASTER_RESET_N,
        rb_en: `PAC_RB_EN_RST,
        ap_write: 1'b0,
        ap_addr: '0,
        rdata: '0,
        ready: 1'b1
    };

    pac_state_t st_q;
    pac_state_t st_d;

    // ============================================================
    // Helpers
    // Bits under a mask one count, the rest stay put
    function automatic logic [ADDR_W-1:0] masked_inc(
        input logic [ADDR_W-1:0] cnt,
        input logic [ADDR_W-1:0] msk
    );
        logic [ADDR_W-1:0] up;
        up = ADDR_W'(cnt + 1'b1);
        return (cnt & ~msk) | (up & msk);
    endfunction

    // Zero-extend a port-width value to a bus word
    function automatic logic [31:0] to_word(input logic [ADDR_W-1:0] v);
        return 32'(v);
    endfunction

    // ============================================================
    // Bus decode
    logic ap_take;
    logic dp_write;
    logic rb_en_now;

    // Transfers of any size are taken; only whole-word writes take effect
    assign ap_take = hsel && htrans[1] && hready;
    assign dp_write = st_q.ap_write;
    // Forward a write still in its data phase to a read behind it
    assign rb_en_now = (dp_write && st_q.ap_addr == `PAC_OFS_CTRL)
        ? hwdata[`PAC_CTRL_RB_EN] : st_q.rb_en;

    // ============================================================
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.ready = 1'b1;

        // Access decode kept for the memory path and the status register
        st_d.selected = !chip_enable_low_active && chip_enable_high_active
            && !(lower_byte_enable_n && upper_byte_enable_n);

        if (!ctrl.counter_reset_n) begin
            st_d.counter = '0;
            st_d.last_op = PAC_OP_CRST;
        end else if (!ctrl.mask_load_n) begin
            st_d.mask = external_address;
            st_d.last_op = PAC_OP_MASK_LD;
        end else if (!ctrl.counter_load_n) begin
            st_d.counter = external_address;
            st_d.last_op = PAC_OP_ADDR_LD;
        end else if (!ctrl.counter_increment_n) begin
            st_d.counter = masked_inc(st_q.counter, st_q.mask);
            st_d.last_op = PAC_OP_INC;
        end else begin
            st_d.last_op = PAC_OP_HOLD;
        end

        // Readback shows values present at the edge
        // Counter readback outranks mask readback when both are asked
        st_d.drive_en_n = 1'b1;
        if (st_q.rb_en && !ctrl.counter_readback_n) begin
            st_d.drive = st_q.counter;
            st_d.drive_en_n = 1'b0;
        end else if (st_q.rb_en && !ctrl.mask_readback_n) begin
            st_d.drive = st_q.mask;
            st_d.drive_en_n = 1'b0;
        end

        // Data phase of a write; unmapped offsets are ignored
        if (dp_write && st_q.ap_addr == `PAC_OFS_CTRL) begin
            st_d.rb_en = hwdata[`PAC_CTRL_RB_EN];
        end

        // Address phase: latch write, prepare read word
        st_d.ap_write = 1'b0;
        if (ap_take) begin
            st_d.ap_addr = haddr[`PAC_HADDR_W-1:0];
            st_d.ap_write = hwrite && hsize == `PAC_HSIZE_WORD;
            case (haddr[`PAC_HADDR_W-1:0])
                `PAC_OFS_COUNT: begin
                    st_d.rdata = to_word(st_q.counter);
                end
                `PAC_OFS_MASK: begin
                    st_d.rdata = to_word(st_q.mask);
                end
                `PAC_OFS_CTRL: begin
                    st_d.rdata = 32'(rb_en_now);
                end
                `PAC_OFS_STAT: begin
                    st_d.rdata = '0;
                    st_d.rdata[`PAC_STAT_OP_LSB +: 3] = st_q.last_op;
                    st_d.rdata[`PAC_STAT_SEL] = st_q.selected;
                    st_d.rdata[`PAC_STAT_DRV] = !st_q.drive_en_n;
                end
                default: begin
                    st_d.rdata = '0;
                end
            endcase
        end
    end

    // ============================================================
    // State register
    // Master reset acts without the clock
    // Release is not synchronised; the host must hold controls idle then
    always_ff @(posedge core_clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            st_q <= ST_INIT;
        end else if (reset) begin
            st_q <= ST_INIT;
        end else begin
            st_q <= st_d;
        end
    end

    // ============================================================
    // Outputs, all straight from the state register
    assign internal_address = st_q.counter;
    assign address_drive = st_q.drive;
    assign address_drive_en_n = st_q.drive_en_n;
    assign access_selected = st_q.selected;
    assign hrdata = st_q.rdata;
    assign hreadyout = st_q.ready;
    assign hresp = 1'b0 & st_q.ready;

    // ============================================================
    // Checks
    logic ld_ok;
    logic inc_ok;
    logic idle_ok;

    // Qualifiers for the lower levels of the chain
    assign ld_ok = ctrl.counter_reset_n && ctrl.mask_load_n;
    assign inc_ok = ld_ok && ctrl.counter_load_n;
    assign idle_ok = inc_ok && ctrl.counter_increment_n;

    chk_crst_zero: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        !ctrl.counter_reset_n |=> internal_address == '0
    ) else $error("counter reset did not clear the address");

    chk_master_reset_n_state: assert property (
        @(posedge core_clk) disable iff (reset)
        !master_reset_n |-> st_q.counter == '0 && (&st_q.mask)
    ) else $error("master reset state wrong");

    chk_mask_load: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        (ctrl.counter_reset_n && !ctrl.mask_load_n) |=>
            st_q.mask == $past(external_address) && $stable(internal_address)
    ) else $error("mask load wrong or counter moved");

    chk_addr_load: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        (ld_ok && !ctrl.counter_load_n) |=>
            internal_address == $past(external_address)
    ) else $error("address load not taken");

    chk_inc_mask: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        (inc_ok && !ctrl.counter_increment_n) |=>
            internal_address == (($past(st_q.counter) & ~$past(st_q.mask))
            | (ADDR_W'($past(st_q.counter) + 1'b1) & $past(st_q.mask)))
    ) else $error("increment gave wrong address");

    chk_inc_default: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        ((&st_q.mask) && inc_ok && !ctrl.counter_increment_n) |=>
            internal_address == ADDR_W'($past(internal_address) + 1'b1)
    ) else $error("default mode did not step by one");

    chk_hold_idle: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        idle_ok ##1 idle_ok |=> $stable(internal_address) && $stable(st_q.mask)
    ) else $error("counter moved while idle");

    chk_rb_count: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        (st_q.rb_en && !ctrl.counter_readback_n) |=>
            !address_drive_en_n && address_drive == $past(internal_address)
    ) else $error("counter readback missing");

    chk_rb_mask: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        (st_q.rb_en && ctrl.counter_readback_n && !ctrl.mask_readback_n) |=>
            !address_drive_en_n && address_drive == $past(st_q.mask)
    ) else $error("mask readback missing");

    chk_ce_indep: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        (chip_enable_low_active && !ctrl.counter_reset_n) ##1
            (inc_ok && !ctrl.counter_increment_n) |=> internal_address != '0
            || st_q.mask[0] == 1'b0
    ) else $error("counter stalled by chip enable");

    chk_drive_rel: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        (ctrl.counter_readback_n && ctrl.mask_readback_n) |=> address_drive_en_n
    ) else $error("address lines left driven");

    // ============================================================
    // Side effects and bus checks
    // Counter-only operations must leave the mask alone
    chk_crst_mask_kept: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        !ctrl.counter_reset_n |=> $stable(st_q.mask)
    ) else $error("counter reset disturbed the mask");

    chk_ld_mask_kept: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        (ld_ok && !ctrl.counter_load_n) |=> $stable(st_q.mask)
    ) else $error("address load disturbed the mask");

    chk_inc_mask_kept: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        (inc_ok && !ctrl.counter_increment_n) |=> $stable(st_q.mask)
    ) else $error("increment disturbed the mask");

    // Readback switched off in software leaves the lines to the host
    chk_rb_off: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        !st_q.rb_en |=> address_drive_en_n
    ) else $error("address lines driven with readback off");

    // Enables only feed the access decode, one edge late
    chk_sel_decode: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        1'b1 |=> access_selected == $past(!chip_enable_low_active
            && chip_enable_high_active && !(lower_byte_enable_n && upper_byte_enable_n))
    ) else $error("access decode wrong");

    // Zero wait states and never an error response
    chk_bus_okay: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        hreadyout && !hresp
    ) else $error("bus stalled or answered with error");

    // Counter read returns the value standing at the address phase
    chk_rd_count: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        (hsel && htrans[1] && hready && !hwrite
            && haddr[`PAC_HADDR_W-1:0] == `PAC_OFS_COUNT) |=>
            hrdata == 32'($past(internal_address))
    ) else $error("counter read returned wrong data");

    // Mask read returns the value standing at the address phase
    chk_rd_mask: assert property (
        @(posedge core_clk) disable iff (reset || !master_reset_n)
        (hsel && htrans[1] && hready && !hwrite
            && haddr[`PAC_HADDR_W-1:0] == `PAC_OFS_MASK) |=>
            hrdata == 32'($past(st_q.mask))
    ) else $error("mask read returned wrong data");

endmodule // pac_port_counter
`default_nettype wire

//--- sim/pac_host_model.sv
// Host side of one port: drives the shared address lines
`timescale 1ns/1ps
`default_nettype none

module pac_host_model #(
    parameter int ADDR_W = 16
) (
    input wire logic core_clk,
    input wire logic host_drive,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic [ADDR_W-1:0] address_drive,
    input wire logic address_drive_en_n,
    output logic [ADDR_W-1:0] external_address
);
    logic [ADDR_W-1:0] last_q;

    // Wire level; a floating line flips each cycle so stale data never passes
    always_comb begin
        if (!address_drive_en_n) begin
            external_address = address_drive;
        end else if (host_drive) begin
            external_address = host_addr;
        end else begin
            external_address = ~last_q;
        end
    end

    // Last level seen on the lines
    always_ff @(posedge core_clk) begin
        last_q <= external_address;
    end
endmodule // pac_host_model

`default_nettype wire

//--- sim/port_address_counter_mask_bench.sv
// Self-checking bench for the port address counter
`timescale 1ns/1ps
`default_nettype none
`include "pac_cfg.svh"

module port_address_counter_mask_bench;
    import pac_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic master_reset_n = 1'b1;
    pac_ctrl_t ctrl = 6'h3F;
    logic chip_enable_low_active = 1'b1;
    logic chip_enable_high_active = 1'b0;
    logic lower_byte_enable_n = 1'b1;
    logic upper_byte_enable_n = 1'b1;
    logic host_drive = 1'b1;
    logic [15:0] host_addr = 16'h0000;
    logic [15:0] external_address, address_drive, internal_address;
    logic address_drive_en_n, access_selected, hreadyout, hresp;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = `PAC_HSIZE_WORD;
    logic [31:0] hrdata;
    int fail_count = 0;
    int checks_done = 0;

    // ============================================================
    // Clock, design and host
    always #5 core_clk = ~core_clk;

    pac_port_counter dut (.core_clk(core_clk), .reset(reset), .master_reset_n(master_reset_n),
        .ctrl(ctrl), .chip_enable_low_active(chip_enable_low_active),
        .chip_enable_high_active(chip_enable_high_active),
        .lower_byte_enable_n(lower_byte_enable_n), .upper_byte_enable_n(upper_byte_enable_n),
        .external_address(external_address), .address_drive(address_drive),
        .address_drive_en_n(address_drive_en_n), .internal_address(internal_address),
        .access_selected(access_selected), .hsel(hsel), .haddr(haddr), .hwrite(hwrite),
        .htrans(htrans), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

    pac_host_model host (.core_clk(core_clk), .host_drive(host_drive), .host_addr(host_addr),
        .address_drive(address_drive), .address_drive_en_n(address_drive_en_n),
        .external_address(external_address));

    // ============================================================
    // Tasks
    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cnt_is(input logic [15:0] exp);
        check({16'h0000, internal_address}, {16'h0000, exp});
    endtask

    task automatic drv_is(input logic en_n, input logic [15:0] v);
        check({15'h0000, address_drive_en_n, address_drive}, {15'h0000, en_n, v});
    endtask

    task automatic flag_is(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask

    // One pin operation; host lets go of the lines when asking for readback
    task automatic op(input logic [5:0] c, input logic [15:0] a);
        @(posedge core_clk);
        ctrl <= c;
        host_addr <= a;
        host_drive <= c[1] & c[0];
        @(posedge core_clk);
        ctrl <= 6'h3F;
        #1;
    endtask

    // Bounded wait for hready high at an edge
    task automatic wait_ready();
        int n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t: bus wait timed out", $time);
            report_and_stop();
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        check(r, exp);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        // Reset values, unmapped and read-only places
        rd(`PAC_OFS_COUNT, 32'h0);
        rd(`PAC_OFS_MASK, 32'h0000FFFF);
        rd(`PAC_OFS_CTRL, 32'h1);
        rd(32'h10, 32'h0);
        wr(`PAC_OFS_COUNT, 32'h5555);
        rd(`PAC_OFS_COUNT, 32'h0);
        // Chip disabled: load beats increment, then step, then hold
        op(6'h33, 16'h1234);
        cnt_is(16'h1234);
        op(6'h3B, 16'h0BAD);
        cnt_is(16'h1235);
        op(6'h3F, 16'h4321);
        cnt_is(16'h1235);
        // Mask load beats address load and holds the counter
        op(6'h27, 16'h000F);
        cnt_is(16'h1235);
        rd(`PAC_OFS_MASK, 32'h0000000F);
        // Increment wraps inside the masked field
        op(6'h37, 16'h123F);
        op(6'h3B, 16'h0000);
        cnt_is(16'h1230);
        // Both readbacks low: counter wins, then mask alone, then release
        op(6'h3C, 16'h0000);
        drv_is(1'b0, 16'h1230);
        op(6'h3E, 16'h0000);
        drv_is(1'b0, 16'h000F);
        op(6'h3F, 16'h0000);
        flag_is(address_drive_en_n, 1'b1);
        // Readback disabled through the control register
        wr(`PAC_OFS_CTRL, 32'h0);
        op(6'h3D, 16'h0000);
        flag_is(address_drive_en_n, 1'b1);
        wr(`PAC_OFS_CTRL, 32'h1);
        rd(`PAC_OFS_CTRL, 32'h1);
        // Chip enabled: counter reset beats load
        chip_enable_low_active <= 1'b0;
        chip_enable_high_active <= 1'b1;
        lower_byte_enable_n <= 1'b0;
        op(6'h17, 16'h7777);
        cnt_is(16'h0000);
        flag_is(access_selected, 1'b1);
        op(6'h3B, 16'h0000);
        cnt_is(16'h0001);
        // Status: last op hold, access selected, lines released
        rd(`PAC_OFS_STAT, 32'h15);
        // Chip disabled: counter reset and increment on back-to-back edges
        chip_enable_low_active <= 1'b1;
        @(posedge core_clk);
        ctrl <= 6'h1F;
        @(posedge core_clk);
        ctrl <= 6'h3B;
        @(posedge core_clk);
        ctrl <= 6'h3F;
        #1;
        cnt_is(16'h0001);
        flag_is(access_selected, 1'b0);
        // Master reset acts at once, without an edge
        op(6'h37, 16'hABCD);
        op(6'h2F, 16'h00FF);
        @(posedge core_clk);
        master_reset_n <= 1'b0;
        #1;
        cnt_is(16'h0000);
        @(posedge core_clk);
        master_reset_n <= 1'b1;
        rd(`PAC_OFS_MASK, 32'h0000FFFF);
        flag_is(hresp, 1'b0);
        report_and_stop();
    end
endmodule // port_address_counter_mask_bench

`default_nettype wire
